//--- pkg/epf_pkg.sv
package epf_pkg;

   // ****************************************************************
   // Register map and field layout
   // ****************************************************************
   localparam int          ADDR_W          = 4;
   localparam int          DATA_W          = 16;
   localparam logic [3:0]  REG_CTRL        = 4'h0;
   localparam logic [3:0]  REG_PAUSE_TIME  = 4'h1;
   localparam logic [3:0]  REG_WATERMARK   = 4'h2;
   localparam logic [3:0]  REG_PAUSE_LEFT  = 4'h3;
   localparam logic [3:0]  REG_STATUS      = 4'h4;

   localparam int          CTRL_OP_LSB     = 0;
   localparam int          CTRL_AUTO_BIT   = 2;
   localparam int          CTRL_PASS_BIT   = 3;
   localparam int          CTRL_FDX_BIT    = 4;
   localparam int          CTRL_SPD_BIT    = 5;
   localparam int          CTRL_TXREQ_BIT  = 6;
   localparam int          WM_FULL_LSB     = 8;
   localparam int          WM_EMPTY_LSB    = 0;
   localparam int          STAT_BUSY_BIT   = 0;
   localparam int          STAT_PAUSED_BIT = 1;
   localparam int          STAT_FLOW_BIT   = 2;

   // ****************************************************************
   // Flow operation codes
   // ****************************************************************
   localparam logic [1:0]  FLOW_OP_IDLE    = 2'h0;
   localparam logic [1:0]  FLOW_OP_SINGLE  = 2'h1;
   localparam logic [1:0]  FLOW_OP_CONT    = 2'h2;
   localparam logic [1:0]  FLOW_OP_END     = 2'h3;

   // ****************************************************************
   // Reset values
   // ****************************************************************
   localparam logic [5:0]  CTRL_RST        = 6'h00;
   localparam logic [15:0] PAUSE_TIME_RST  = 16'h1000;
   localparam logic [7:0]  WM_FULL_RST     = 8'h10;
   localparam logic [7:0]  WM_EMPTY_RST    = 8'h0f;
   localparam logic [47:0] PAUSE_DEST_ADDR = 48'h0108c2000001;

   // ****************************************************************
   // Timing
   // ****************************************************************
   localparam int          CLK_PERIOD_PS   = 100000;
   localparam int          BIT_PS_100      = 10000;
   localparam int          BIT_PS_10       = 100000;
   localparam int          QUANTUM_BITS    = 512;
   localparam int          IPG_BITS        = 96;
   // Least times, so round up
   localparam int          QUANTUM_CYC_100 = (QUANTUM_BITS * BIT_PS_100 + CLK_PERIOD_PS - 1)
                                             / CLK_PERIOD_PS;
   localparam int          QUANTUM_CYC_10  = (QUANTUM_BITS * BIT_PS_10 + CLK_PERIOD_PS - 1)
                                             / CLK_PERIOD_PS;
   localparam int          IPG_CYC_100     = (IPG_BITS * BIT_PS_100 + CLK_PERIOD_PS - 1)
                                             / CLK_PERIOD_PS;
   localparam int          IPG_CYC_10      = (IPG_BITS * BIT_PS_10 + CLK_PERIOD_PS - 1)
                                             / CLK_PERIOD_PS;
   localparam logic [16:0] BLOCK_BYTES     = 17'h00060;

   typedef enum logic [1:0] {ST_IDLE, ST_GAP, ST_FRAME, ST_CTRL} epf_tx_e;

endpackage : epf_pkg

//--- rtl/epf_quanta_tick.sv
`timescale 1ns/1ns
module epf_quanta_tick
   import epf_pkg::*;
#(
   parameter int CNT_W = 10
) (
   // Clock and reset
   input  wire logic CLOCK,
   input  wire logic NRST,
   // Control
   input  wire logic SPEED_100,
   input  wire logic RESTART,
   // One pulse per pause quantum
   output logic      TICK
);

   if (QUANTUM_CYC_10 >= (1 << CNT_W)) begin : g_cnt_chk
      $error("epf_quanta_tick: CNT_W too small for a quantum");
   end

   logic [CNT_W-1:0] cnt_ff;
   logic [CNT_W-1:0] nxt_cnt;
   logic             tick_ff;
   logic             nxt_tick;
   logic [CNT_W-1:0] last;

   // A quantum is 512 bit times at the live link rate [RULE_02]
   always_comb begin
      last     = SPEED_100 ? CNT_W'(QUANTUM_CYC_100 - 1) : CNT_W'(QUANTUM_CYC_10 - 1);
      nxt_tick = 1'b0;
      nxt_cnt  = cnt_ff + 1'b1;
      if (RESTART) begin
         nxt_cnt = '0;
      end else if (cnt_ff >= last) begin
         nxt_cnt  = '0;
         nxt_tick = 1'b1;
      end
   end

   always_ff @(posedge CLOCK) begin
      if (!NRST) begin
         cnt_ff  <= '0;
         tick_ff <= 1'b0;
      end else begin
         cnt_ff  <= nxt_cnt;
         tick_ff <= nxt_tick;
      end
   end

   assign TICK = tick_ff;

endmodule : epf_quanta_tick

//--- rtl/epf_flow_ctrl.sv
`timescale 1ns/1ns
// What this block does
// RULE_01: Pause frames go to reserved multicast address
// RULE_02: Pause quantum equals 512 bit times
// RULE_03: Reception continues while transmitter is paused
// RULE_04: New pause frame restarts timer from value
// RULE_05: Zero pause time ends pause at once
// RULE_06: Decode pause frames, block transmit while timed
// RULE_07: Transmit request stays set until frame sent
// RULE_08: Received pause frames dropped by default
// RULE_09: Pass-all stores pause frames, ignores their effect
// RULE_10: Sent pause frames carry programmed pause time
// RULE_11: Manual control unless automatic enable is set
// RULE_12: Code 01 sends one frame, returns idle
// RULE_13: Code 10 repeats pause frames until 11
// RULE_14: Code 11 sends zero-time frame, then idle
// RULE_15: Half duplex software uses 10 and 00
// RULE_16: Auto starts above full, stops below empty
// RULE_17: Watermark upper byte full, lower empty
// RULE_18: Auto mode owns code, reads 10 or 00
// RULE_19: Watermarks reset to sixteen and fifteen blocks
// RULE_20: Software keeps empty below full watermark
// RULE_21: Software programs pause time before enabling
// RULE_22: Half duplex nonzero code jams the medium
// RULE_23: Queued frame stops jam, gap, send, rejam
// RULE_24: Timer drops per quantum, releases at zero
// RULE_25: Repeat before advertised pause runs out
module epf_flow_ctrl
   import epf_pkg::*;
#(
   parameter int GAP_W = 8
) (
   // Clock and reset
   input  wire logic              CLOCK,
   input  wire logic              NRST,
   // Register port
   input  wire logic [ADDR_W-1:0] ADDR,
   input  wire logic [DATA_W-1:0] WDATA,
   input  wire logic              WR,
   input  wire logic              RD,
   output logic      [DATA_W-1:0] RDATA,
   // Receive side
   input  wire logic              RX_FRAME_END,
   input  wire logic              RX_IS_PAUSE,
   input  wire logic [15:0]       RX_PAUSE_TIME,
   input  wire logic              RX_FILTER_OK,
   input  wire logic [15:0]       RX_BUF_BYTES,
   output logic                   RX_STORE,
   output logic                   RX_DROP,
   // Data frame transmit
   output logic                   TX_START,
   input  wire logic              TX_DONE,
   // Control frame transmit
   output logic                   CF_REQ,
   input  wire logic              CF_ACK,
   output logic      [47:0]       CF_DEST_ADDR,
   output logic      [15:0]       CF_PAUSE_TIME,
   // Medium and status
   output logic                   JAM_EN,
   output logic                   TX_PAUSED,
   output logic                   FLOW_ACTIVE
);

   if (IPG_CYC_10 >= (1 << GAP_W)) begin : g_gap_chk
      $error("epf_flow_ctrl: GAP_W too small for the inter-packet gap");
   end

   // ****************************************************************
   // Helpers
   // ****************************************************************
   function automatic logic [16:0] blocks_to_bytes(input logic [7:0] blocks);
      return 17'(blocks) * BLOCK_BYTES;
   endfunction : blocks_to_bytes

   function automatic logic [15:0] half_min_one(input logic [15:0] t);
      return (t > 16'h0001) ? {1'b0, t[15:1]} : 16'h0001;
   endfunction : half_min_one

   // ****************************************************************
   // State
   // ****************************************************************
   logic [1:0]        op_ff,        nxt_op;
   logic              auto_ff,      nxt_auto;
   logic              pass_ff,      nxt_pass;
   logic              fdx_ff,       nxt_fdx;
   logic              spd_ff,       nxt_spd;
   logic              txreq_ff,     nxt_txreq;
   logic [15:0]       ptime_ff,     nxt_ptime;
   logic [7:0]        wm_full_ff,   nxt_wm_full;
   logic [7:0]        wm_empty_ff,  nxt_wm_empty;
   logic              flow_ff,      nxt_flow;
   logic [15:0]       pause_q_ff,   nxt_pause_q;
   logic [15:0]       rep_q_ff,     nxt_rep_q;
   epf_tx_e           st_ff,        nxt_st;
   logic [GAP_W-1:0]  gap_ff,       nxt_gap;
   logic              start_ff,     nxt_start;
   logic              cfreq_ff,     nxt_cfreq;
   logic [15:0]       cftime_ff,    nxt_cftime;
   logic [47:0]       cfdest_ff;
   logic              jam_ff,       nxt_jam;
   logic              store_ff,     nxt_store;
   logic              drop_ff,      nxt_drop;
   logic [DATA_W-1:0] rdata_ff,     nxt_rdata;
   // Registered copy so the status pin comes from a flip-flop
   logic              paused_out_ff;

   logic              tick;
   logic              rx_pause_hit;
   logic              paused;
   logic              ctrl_wr;
   logic              cf_due;
   logic              hw_op_clear;
   logic [16:0]       buf_bytes;

   // Pause frames act only while pass-all is clear [RULE_06] [RULE_09]
   assign rx_pause_hit = RX_FRAME_END && RX_IS_PAUSE && !pass_ff;
   assign paused       = (pause_q_ff != 16'h0000) && !pass_ff;
   assign ctrl_wr      = WR && (ADDR == REG_CTRL);
   assign buf_bytes    = {1'b0, RX_BUF_BYTES};

   epf_quanta_tick u_tick (
      .CLOCK     (CLOCK),
      .NRST      (NRST),
      .SPEED_100 (spd_ff),
      .RESTART   (rx_pause_hit),
      .TICK      (tick)
   );

   // ****************************************************************
   // Receive path: store or drop at frame end
   // ****************************************************************
   // Reception never looks at the pause state [RULE_03]
   always_comb begin
      nxt_store = 1'b0;
      nxt_drop  = 1'b0;
      if (RX_FRAME_END) begin
         if (RX_IS_PAUSE && !pass_ff) begin
            nxt_drop = 1'b1; // [RULE_08]
         end else begin
            nxt_store = RX_FILTER_OK; // [RULE_09]
            nxt_drop  = !RX_FILTER_OK;
         end
      end
   end

   // ****************************************************************
   // Pause timer and repeat timer
   // ****************************************************************
   always_comb begin
      nxt_pause_q = pause_q_ff;
      if (rx_pause_hit) begin
         // Zero here ends the pause in the next cycle [RULE_04] [RULE_05]
         nxt_pause_q = RX_PAUSE_TIME;
      end else if (tick && (pause_q_ff != 16'h0000)) begin
         nxt_pause_q = pause_q_ff - 16'h0001; // [RULE_24]
      end
   end

   always_comb begin
      nxt_rep_q = rep_q_ff;
      if ((st_ff == ST_CTRL) && CF_ACK && (op_ff == FLOW_OP_CONT)) begin
         // Half the advertised time leaves margin for the next frame [RULE_25]
         nxt_rep_q = half_min_one(ptime_ff);
      end else if (op_ff != FLOW_OP_CONT) begin
         nxt_rep_q = 16'h0000;
      end else if (tick && (rep_q_ff != 16'h0000)) begin
         nxt_rep_q = rep_q_ff - 16'h0001;
      end
   end

   // ****************************************************************
   // Transmit sequencer
   // ****************************************************************
   always_comb begin
      cf_due      = fdx_ff && (op_ff != FLOW_OP_IDLE)
                    && ((op_ff != FLOW_OP_CONT) || (rep_q_ff == 16'h0000)); // [RULE_13]
      nxt_st      = st_ff;
      nxt_gap     = gap_ff;
      nxt_start   = 1'b0;
      nxt_cfreq   = cfreq_ff;
      nxt_cftime  = cftime_ff;
      hw_op_clear = 1'b0;
      case (st_ff)
         ST_IDLE: begin
            if (cf_due) begin
               nxt_cfreq  = 1'b1;
               // Terminating frame carries zero time [RULE_10] [RULE_14]
               nxt_cftime = (op_ff == FLOW_OP_END) ? 16'h0000 : ptime_ff;
               nxt_st     = ST_CTRL;
            end else if (txreq_ff && !paused) begin // [RULE_06] [RULE_07]
               if (jam_ff) begin
                  // Medium was jammed: let it rest one gap first [RULE_23]
                  nxt_gap = spd_ff ? GAP_W'(IPG_CYC_100) : GAP_W'(IPG_CYC_10);
                  nxt_st  = ST_GAP;
               end else begin
                  nxt_start = 1'b1;
                  nxt_st    = ST_FRAME;
               end
            end
         end
         ST_GAP: begin
            if (gap_ff <= GAP_W'(1)) begin
               nxt_gap   = '0;
               nxt_start = 1'b1;
               nxt_st    = ST_FRAME;
            end else begin
               nxt_gap = gap_ff - GAP_W'(1);
            end
         end
         ST_FRAME: begin
            if (TX_DONE) begin
               nxt_st = ST_IDLE;
            end
         end
         ST_CTRL: begin
            if (CF_ACK) begin
               nxt_cfreq   = 1'b0;
               // A code rewritten to 11 while a nonzero-time frame was out keeps its own frame; 01 is cleared
               hw_op_clear = (op_ff == FLOW_OP_SINGLE)
                             || ((op_ff == FLOW_OP_END) && (cftime_ff == 16'h0000)); // [RULE_12]
               nxt_st      = ST_IDLE;
            end
         end
         default: begin
            nxt_st    = ST_IDLE;
            nxt_cfreq = 1'b0;
         end
      endcase
   end

   // ****************************************************************
   // Control register, automatic engine and watermarks
   // ****************************************************************
   always_comb begin
      nxt_op       = op_ff;
      nxt_auto     = auto_ff;
      nxt_pass     = pass_ff;
      nxt_fdx      = fdx_ff;
      nxt_spd      = spd_ff;
      nxt_txreq    = txreq_ff;
      nxt_ptime    = ptime_ff;
      nxt_wm_full  = wm_full_ff;
      nxt_wm_empty = wm_empty_ff;
      nxt_flow     = flow_ff;
      if ((st_ff == ST_FRAME) && TX_DONE) begin
         nxt_txreq = 1'b0; // [RULE_07]
      end
      if (hw_op_clear) begin
         nxt_op = FLOW_OP_IDLE; // [RULE_12] [RULE_14]
      end
      if (ctrl_wr) begin
         nxt_auto = WDATA[CTRL_AUTO_BIT]; // [RULE_11]
         nxt_pass = WDATA[CTRL_PASS_BIT];
         nxt_fdx  = WDATA[CTRL_FDX_BIT];
         nxt_spd  = WDATA[CTRL_SPD_BIT];
         // Software set wins over a same-cycle completion
         if (WDATA[CTRL_TXREQ_BIT]) begin
            nxt_txreq = 1'b1;
         end
         // The automatic engine owns the code; writes are ignored [RULE_18]
         if (!auto_ff) begin
            nxt_op = WDATA[CTRL_OP_LSB +: 2]; // [RULE_15]
         end
      end
      if (WR && (ADDR == REG_PAUSE_TIME)) begin
         nxt_ptime = WDATA; // [RULE_21]
      end
      if (WR && (ADDR == REG_WATERMARK)) begin
         nxt_wm_full  = WDATA[WM_FULL_LSB +: 8]; // [RULE_17]
         nxt_wm_empty = WDATA[WM_EMPTY_LSB +: 8];
      end
      if (auto_ff) begin
         if (!flow_ff && (buf_bytes > blocks_to_bytes(wm_full_ff))) begin
            nxt_flow = 1'b1; // [RULE_16]
            nxt_op   = FLOW_OP_CONT;
         end else if (flow_ff && (buf_bytes < blocks_to_bytes(wm_empty_ff))) begin
            nxt_flow = 1'b0;
            // Full duplex tells the partner to resume; half duplex just stops
            nxt_op   = fdx_ff ? FLOW_OP_END : FLOW_OP_IDLE;
         end
      end else begin
         nxt_flow = 1'b0;
      end
   end

   // Jam only in half duplex with a nonzero code and no frame under way [RULE_22]
   always_comb begin
      nxt_jam = !fdx_ff && (nxt_op != FLOW_OP_IDLE) && (nxt_st == ST_IDLE)
                && !(txreq_ff && !paused); // [RULE_23]
   end

   // ****************************************************************
   // Register read
   // ****************************************************************
   always_comb begin
      nxt_rdata = '0;
      if (RD) begin
         case (ADDR)
            REG_CTRL: begin
               // Automatic mode shows only active or idle [RULE_18]
               nxt_rdata[CTRL_OP_LSB +: 2] = auto_ff ? (flow_ff ? FLOW_OP_CONT : FLOW_OP_IDLE)
                                                     : op_ff;
               nxt_rdata[CTRL_AUTO_BIT]    = auto_ff;
               nxt_rdata[CTRL_PASS_BIT]    = pass_ff;
               nxt_rdata[CTRL_FDX_BIT]     = fdx_ff;
               nxt_rdata[CTRL_SPD_BIT]     = spd_ff;
               nxt_rdata[CTRL_TXREQ_BIT]   = txreq_ff;
            end
            REG_PAUSE_TIME: begin
               nxt_rdata = ptime_ff;
            end
            REG_WATERMARK: begin
               nxt_rdata = {wm_full_ff, wm_empty_ff};
            end
            REG_PAUSE_LEFT: begin
               nxt_rdata = pause_q_ff;
            end
            REG_STATUS: begin
               nxt_rdata[STAT_BUSY_BIT]   = (st_ff != ST_IDLE);
               nxt_rdata[STAT_PAUSED_BIT] = paused;
               nxt_rdata[STAT_FLOW_BIT]   = flow_ff;
            end
            default: begin
               nxt_rdata = '0;
            end
         endcase
      end
   end

   // ****************************************************************
   // Registers
   // ****************************************************************
   always_ff @(posedge CLOCK) begin
      if (!NRST) begin
         op_ff       <= CTRL_RST[CTRL_OP_LSB +: 2];
         auto_ff     <= CTRL_RST[CTRL_AUTO_BIT]; // [RULE_11]
         pass_ff     <= CTRL_RST[CTRL_PASS_BIT];
         fdx_ff      <= CTRL_RST[CTRL_FDX_BIT];
         spd_ff      <= CTRL_RST[CTRL_SPD_BIT];
         txreq_ff    <= 1'b0;
         ptime_ff    <= PAUSE_TIME_RST;
         wm_full_ff  <= WM_FULL_RST; // [RULE_19]
         wm_empty_ff <= WM_EMPTY_RST;
         flow_ff     <= 1'b0;
         pause_q_ff  <= 16'h0000;
         rep_q_ff    <= 16'h0000;
         st_ff       <= ST_IDLE;
         gap_ff      <= '0;
         start_ff    <= 1'b0;
         cfreq_ff    <= 1'b0;
         cftime_ff   <= 16'h0000;
         cfdest_ff   <= PAUSE_DEST_ADDR; // [RULE_01]
         jam_ff      <= 1'b0;
         store_ff    <= 1'b0;
         drop_ff     <= 1'b0;
         rdata_ff    <= '0;
         paused_out_ff <= 1'b0;
      end else begin
         op_ff       <= nxt_op;
         auto_ff     <= nxt_auto;
         pass_ff     <= nxt_pass;
         fdx_ff      <= nxt_fdx;
         spd_ff      <= nxt_spd;
         txreq_ff    <= nxt_txreq;
         ptime_ff    <= nxt_ptime;
         wm_full_ff  <= nxt_wm_full;
         wm_empty_ff <= nxt_wm_empty;
         flow_ff     <= nxt_flow;
         pause_q_ff  <= nxt_pause_q;
         rep_q_ff    <= nxt_rep_q;
         st_ff       <= nxt_st;
         gap_ff      <= nxt_gap;
         start_ff    <= nxt_start;
         cfreq_ff    <= nxt_cfreq;
         cftime_ff   <= nxt_cftime;
         cfdest_ff   <= PAUSE_DEST_ADDR;
         jam_ff      <= nxt_jam;
         store_ff    <= nxt_store;
         drop_ff     <= nxt_drop;
         rdata_ff    <= nxt_rdata;
         paused_out_ff <= (nxt_pause_q != 16'h0000) && !nxt_pass;
      end
   end

   assign RDATA         = rdata_ff;
   assign RX_STORE      = store_ff;
   assign RX_DROP       = drop_ff;
   assign TX_START      = start_ff;
   assign CF_REQ        = cfreq_ff;
   assign CF_DEST_ADDR  = cfdest_ff;
   assign CF_PAUSE_TIME = cftime_ff;
   assign JAM_EN        = jam_ff;
   assign TX_PAUSED     = paused_out_ff;
   assign FLOW_ACTIVE   = flow_ff;

endmodule : epf_flow_ctrl

//--- dv/epf_flow_chk.sv
`timescale 1ns/1ns
module epf_flow_chk
   import epf_pkg::*;
(
   // Clock and reset
   input wire logic        CLOCK,
   input wire logic        NRST,
   // Register read
   input wire logic        RD,
   input wire logic [15:0] RDATA,
   // Receive
   input wire logic        RX_FRAME_END,
   input wire logic        RX_IS_PAUSE,
   input wire logic [15:0] RX_PAUSE_TIME,
   input wire logic        RX_FILTER_OK,
   input wire logic        RX_STORE,
   input wire logic        RX_DROP,
   // Transmit
   input wire logic        TX_START,
   input wire logic        CF_REQ,
   input wire logic        CF_ACK,
   input wire logic [47:0] CF_DEST_ADDR,
   input wire logic [15:0] CF_PAUSE_TIME,
   input wire logic        JAM_EN,
   input wire logic        TX_PAUSED
);
   // ****************************************************************
   // Pause handling
   // ****************************************************************
   default clocking cb @(posedge CLOCK); endclocking
   default disable iff (!NRST);

   sequence timed_drop_s;
      RX_FRAME_END && RX_IS_PAUSE && RX_PAUSE_TIME != 16'h0000 && RX_FILTER_OK ##1 RX_DROP;
   endsequence
   sequence zero_pause_s;
      RX_FRAME_END && RX_IS_PAUSE && RX_PAUSE_TIME == 16'h0000;
   endsequence

   dest_addr_a: assert property (CF_DEST_ADDR == 48'h0108c2000001)
      else $error("pause destination address wrong");
   rx_answer_a: assert property (RX_FRAME_END |=> RX_STORE != RX_DROP)
      else $error("frame neither stored nor dropped once");
   pause_load_a: assert property (timed_drop_s |-> TX_PAUSED)
      else $error("pause frame did not pause transmit");
   zero_end_a: assert property (zero_pause_s |=> !TX_PAUSED)
      else $error("zero pause did not end pause");
   no_start_a: assert property (TX_PAUSED |=> !TX_START)
      else $error("data frame started while paused");
   jam_gap_a: assert property (TX_START |-> !JAM_EN)
      else $error("data frame started under jam");
   cf_hold_a: assert property (CF_REQ && !CF_ACK |=> CF_REQ && $stable(CF_PAUSE_TIME))
      else $error("pause request dropped or time changed");
   cf_release_a: assert property (CF_REQ && CF_ACK |=> !CF_REQ)
      else $error("pause request held after acknowledge");
   rdata_idle_a: assert property (!RD |=> RDATA == 16'h0000)
      else $error("read data outside read slot");
endmodule : epf_flow_chk

//--- dv/epf_far_end.sv
`timescale 1ns/1ns
module epf_far_end (
   // Clock and reset
   input  wire logic        CLOCK,
   input  wire logic        NRST,
   // Pause frame sender
   input  wire logic        CF_REQ,
   input  wire logic [15:0] CF_PAUSE_TIME,
   output logic             CF_ACK,
   // Data frame sender
   input  wire logic        TX_START,
   output logic             TX_DONE
);
   // ****************************************************************
   // Medium side of both frame senders
   // ****************************************************************
   logic [15:0] cf_cnt, cf_time, tx_cnt;
   logic [2:0]  cf_wait, tx_wait;

   // Frames take several cycles, so the design must hold CF_REQ until CF_ACK; TX_START is a single pulse
   always @(posedge CLOCK) begin
      CF_ACK <= 1'b0;
      TX_DONE <= 1'b0;
      if (!NRST) begin
         cf_cnt <= 16'h0;
         cf_time <= 16'h0;
         tx_cnt <= 16'h0;
         cf_wait <= 3'h0;
         tx_wait <= 3'h0;
      end else begin
         if (CF_REQ && !CF_ACK) begin
            cf_wait <= cf_wait + 3'h1;
            if (cf_wait == 3'h3) begin
               CF_ACK <= 1'b1;
               cf_cnt <= cf_cnt + 16'h1;
               cf_time <= CF_PAUSE_TIME;
               cf_wait <= 3'h0;
            end
         end
         if (TX_START)
            tx_wait <= 3'h5;
         else if (tx_wait == 3'h1) begin
            TX_DONE <= 1'b1;
            tx_cnt <= tx_cnt + 16'h1;
            tx_wait <= 3'h0;
         end else if (tx_wait != 3'h0)
            tx_wait <= tx_wait - 3'h1;
      end
   end
endmodule : epf_far_end

//--- dv/tb_top.sv
`timescale 1ns/1ns
module tb_top;
   import epf_pkg::*;
   // ****************************************************************
   // Stimulus and instances
   // ****************************************************************
   logic CLOCK = 1'b0, NRST = 1'b0, WR = 1'b0, RD = 1'b0, RX_FRAME_END = 1'b0;
   logic RX_IS_PAUSE = 1'b0, RX_FILTER_OK = 1'b0;
   logic [3:0]  ADDR = 4'h0;
   logic [15:0] WDATA = 16'h0, RX_PAUSE_TIME = 16'h0, RX_BUF_BYTES = 16'h0;
   logic [15:0] RDATA, CF_PAUSE_TIME;
   logic [47:0] CF_DEST_ADDR;
   logic        RX_STORE, RX_DROP, TX_START, TX_DONE, CF_REQ, CF_ACK;
   logic        JAM_EN, TX_PAUSED, FLOW_ACTIVE;
   int          errors = 0, checked = 0;

   epf_flow_ctrl uut (.*);
   epf_far_end far (.*);

   initial forever #50 CLOCK = ~CLOCK;

   task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
      checked++;
      if (g !== e) begin
         errors++;
         $display("mismatch %s expected %h seen %h", n, e, g);
      end
   endtask : chk
   task automatic cyc(input int n);
      repeat (n) @(posedge CLOCK);
      #1;
   endtask : cyc
   task automatic wr(input logic [3:0] a, input logic [15:0] d);
      @(posedge CLOCK);
      ADDR <= a;
      WDATA <= d;
      WR <= 1'b1;
      @(posedge CLOCK);
      WR <= 1'b0;
   endtask : wr
   task automatic rd(input logic [3:0] a, input logic [15:0] e);
      @(posedge CLOCK);
      ADDR <= a;
      RD <= 1'b1;
      @(posedge CLOCK);
      RD <= 1'b0;
      #1 chk("rdata", e, RDATA);
   endtask : rd
   // The pause time field is inverted once the frame-end pulse is gone
   task automatic rx(input logic p, input logic [15:0] t, input logic ok, input logic st);
      @(posedge CLOCK);
      RX_FRAME_END <= 1'b1;
      RX_IS_PAUSE <= p;
      RX_PAUSE_TIME <= t;
      RX_FILTER_OK <= ok;
      @(posedge CLOCK);
      RX_FRAME_END <= 1'b0;
      RX_PAUSE_TIME <= ~t;
      #1 chk("store", st, RX_STORE);
      chk("drop", !st, RX_DROP);
   endtask : rx
   task automatic lv(input logic [15:0] v, input logic f);
      @(posedge CLOCK);
      RX_BUF_BYTES <= v;
      cyc(5);
      chk("flow", f, FLOW_ACTIVE);
   endtask : lv
   task automatic close_out();
      $display("comparisons %0d mismatches %0d", checked, errors);
      if (errors == 0 && checked > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask : close_out

   initial begin
      repeat (5000) @(posedge CLOCK);
      errors++;
      close_out();
   end

   initial begin
      repeat (10) @(posedge CLOCK);
      NRST <= 1'b1;
      rd(REG_CTRL, 16'h0000);
      rd(REG_WATERMARK, 16'h100f);
      wr(REG_WATERMARK, 16'h2010);
      rd(REG_WATERMARK, 16'h2010);
      wr(4'hf, 16'hffff);
      rd(4'hf, 16'h0000);
      $display("test registers ended");
      wr(REG_PAUSE_TIME, 16'h0002);
      wr(REG_CTRL, 16'h0031);
      cyc(20);
      chk("cf count", 16'h1, far.cf_cnt);
      chk("cf time", 16'h0002, far.cf_time);
      rd(REG_CTRL, 16'h0030);
      wr(REG_CTRL, 16'h0033);
      cyc(20);
      chk("cf time", 16'h0000, far.cf_time);
      rd(REG_CTRL, 16'h0030);
      wr(REG_CTRL, 16'h0032);
      cyc(200);
      chk("cf repeat", 1'b1, far.cf_cnt >= 16'h5);
      wr(REG_CTRL, 16'h0033);
      cyc(20);
      chk("cf time", 16'h0000, far.cf_time);
      rd(REG_CTRL, 16'h0030);
      $display("test pause send ended");
      rx(1'b1, 16'h0002, 1'b1, 1'b0);
      chk("paused", 1'b1, TX_PAUSED);
      wr(REG_CTRL, 16'h0070);
      cyc(40);
      rd(REG_CTRL, 16'h0070);
      cyc(50);
      chk("paused", 1'b1, TX_PAUSED);
      chk("sent", 16'h0, far.tx_cnt);
      cyc(50);
      chk("paused", 1'b0, TX_PAUSED);
      chk("sent", 16'h1, far.tx_cnt);
      rd(REG_CTRL, 16'h0030);
      rx(1'b1, 16'h0001, 1'b1, 1'b0);
      cyc(30);
      rx(1'b1, 16'h0003, 1'b1, 1'b0);
      cyc(60);
      chk("paused", 1'b1, TX_PAUSED);
      rd(REG_PAUSE_LEFT, 16'h0002);
      rd(REG_STATUS, 16'h0002);
      rx(1'b0, 16'h0000, 1'b1, 1'b1);
      rx(1'b1, 16'h0000, 1'b1, 1'b0);
      chk("paused", 1'b0, TX_PAUSED);
      wr(REG_CTRL, 16'h0038);
      rx(1'b1, 16'h0005, 1'b1, 1'b1);
      chk("paused", 1'b0, TX_PAUSED);
      rx(1'b1, 16'h0005, 1'b0, 1'b0);
      $display("test pause receive ended");
      wr(REG_CTRL, 16'h0030);
      wr(REG_WATERMARK, 16'h0201);
      wr(REG_CTRL, 16'h0034);
      lv(16'd192, 1'b0);
      lv(16'd193, 1'b1);
      rd(REG_CTRL, 16'h0036);
      wr(REG_CTRL, 16'h0035);
      rd(REG_CTRL, 16'h0036);
      lv(16'd96, 1'b1);
      lv(16'd95, 1'b0);
      rd(REG_CTRL, 16'h0034);
      cyc(20);
      chk("cf time", 16'h0000, far.cf_time);
      wr(REG_CTRL, 16'h0030);
      lv(16'd0, 1'b0);
      $display("test automatic ended");
      wr(REG_CTRL, 16'h0022);
      cyc(3);
      chk("jam", 1'b1, JAM_EN);
      wr(REG_CTRL, 16'h0062);
      cyc(40);
      chk("sent", 16'h2, far.tx_cnt);
      chk("jam", 1'b1, JAM_EN);
      wr(REG_CTRL, 16'h0020);
      cyc(3);
      chk("jam", 1'b0, JAM_EN);
      $display("test half duplex ended");
      close_out();
   end
endmodule : tb_top

bind epf_flow_ctrl epf_flow_chk chk_i (.*);
